//--- ams_async_mem_seq.sv
// Sequencer for the external asynchronous memory port
// Operation
// - Phase lengths are whole interface clock periods
// - Read lasts setup+strobe+hold+turnaround+4 cycles
// - Write lasts setup+strobe+hold+turnaround+4 cycles
// - Turnaround gap lasts turnaround count plus one
// - Read address valid setup+1 before OE low
// - Output enable low for read strobe+1
// - Read address held hold+1 after OE high
// - Capture read data at OE rising edge
// - Write address valid setup+1 before WE low
// - Write enable low for write strobe+1
// - Write address held hold+1 after WE high
// - Write data driven setup+1 before WE low
// - Write data kept hold+1 after WE high
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ams_async_mem_seq
   import ams_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               rst_b,
   input  wire logic [RADDR_W-1:0] reg_addr,
   input  wire logic [RDATA_W-1:0] reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [RDATA_W-1:0] reg_rdata,
   output logic                    ext_chip_select_n,
   output logic                    ext_output_enable_n,
   output logic                    ext_write_enable_n,
   output logic      [WADDR_W-1:0] ext_word_address,
   output logic      [BADDR_W-1:0] ext_byte_address,
   input  wire logic [DATA_W-1:0]  ext_data_in,
   output logic      [DATA_W-1:0]  ext_data_out,
   output logic                    ext_data_oe
);
   // ==========================================================
   // Reset release
   logic rst_s1_r;
   logic rst_n;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end
   // ==========================================================
   // Registers
   logic [TIM_W-1:0]         rtim_r, rtim_nxt;
   logic [TIM_W-1:0]         wtim_r, wtim_nxt;
   logic [CNT_W-1:0]         turn_r, turn_nxt;
   logic [WADDR_W+BADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0]        wdat_r, wdat_nxt;
   logic [DATA_W-1:0]        rdat_r, rdat_nxt;
   logic                     done_r, done_nxt;
   logic                     isw_r, isw_nxt;
   logic [RDATA_W-1:0]       rd_r, rd_nxt;
   logic                     go_rd, go_wr, busy, acc_end;
   logic                     cap_vld_r, cap_vld_nxt;
   logic [DATA_W-1:0]        cap_r, cap_nxt;
   ams_state_e               state_r, state_nxt;
   assign busy  = (state_r != ST_IDLE);
   // Timing is locked while busy so the running access stays coherent
   assign go_rd = reg_wr && reg_addr == OFS_CMD && !busy
                  && reg_wdata[CMD_READ];
   assign go_wr = reg_wr && reg_addr == OFS_CMD && !busy
                  && !reg_wdata[CMD_READ] && reg_wdata[CMD_WRITE];
   always_comb begin
      rtim_nxt = rtim_r;
      wtim_nxt = wtim_r;
      turn_nxt = turn_r;
      addr_nxt = addr_r;
      wdat_nxt = wdat_r;
      done_nxt = done_r;
      rdat_nxt = cap_vld_r ? cap_r : rdat_r;
      rd_nxt   = '0;
      if (reg_wr && !busy) begin
         if (reg_addr == OFS_RTIM) begin
            rtim_nxt = reg_wdata[TIM_W-1:0];
         end else if (reg_addr == OFS_WTIM) begin
            wtim_nxt = reg_wdata[TIM_W-1:0];
         end else if (reg_addr == OFS_TURN) begin
            turn_nxt = reg_wdata[CNT_W-1:0];
         end else if (reg_addr == OFS_ADDR) begin
            addr_nxt = reg_wdata[WADDR_W+BADDR_W-1:0];
         end else if (reg_addr == OFS_WDATA) begin
            wdat_nxt = reg_wdata[DATA_W-1:0];
         end
      end
      if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[STS_DONE]) begin
         done_nxt = 1'b0;
      end
      if (acc_end) begin // Completion beats a clear in one cycle
         done_nxt = 1'b1;
      end
      if (reg_rd) begin
         if (reg_addr == OFS_RTIM) begin
            rd_nxt[TIM_W-1:0] = rtim_r;
         end else if (reg_addr == OFS_WTIM) begin
            rd_nxt[TIM_W-1:0] = wtim_r;
         end else if (reg_addr == OFS_TURN) begin
            rd_nxt[CNT_W-1:0] = turn_r;
         end else if (reg_addr == OFS_ADDR) begin
            rd_nxt[WADDR_W+BADDR_W-1:0] = addr_r;
         end else if (reg_addr == OFS_WDATA) begin
            rd_nxt[DATA_W-1:0] = wdat_r;
         end else if (reg_addr == OFS_STATUS) begin
            rd_nxt[STS_BUSY]  = busy;
            rd_nxt[STS_DONE]  = done_r;
            rd_nxt[STS_WRITE] = isw_r;
         end else if (reg_addr == OFS_RDATA) begin
            rd_nxt[DATA_W-1:0] = rdat_r;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rtim_r <= RST_TIM;
         wtim_r <= RST_TIM;
         turn_r <= RST_TURN;
         addr_r <= '0;
         wdat_r <= '0;
         rdat_r <= '0;
         done_r <= 1'b0;
         rd_r   <= '0;
      end else begin
         rtim_r <= rtim_nxt;
         wtim_r <= wtim_nxt;
         turn_r <= turn_nxt;
         addr_r <= addr_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         done_r <= done_nxt;
         rd_r   <= rd_nxt;
      end
   end
   assign reg_rdata = rd_r;
   // ==========================================================
   // Access sequencer
   logic [TIM_W-1:0] tim;
   logic [CNT_W-1:0] c_set, c_stb, c_hld, tmr_val;
   logic             tmr_load, tmr_last;
   logic             cs_nxt, oe_nxt, we_nxt, doe_nxt, cs_r, oe_r, we_r, doe_r;
   logic [WADDR_W+BADDR_W-1:0] pa_r, pa_nxt;
   logic [DATA_W-1:0] pd_r, pd_nxt;
   assign tim   = isw_r ? wtim_r : rtim_r;
   assign c_set = tim[FLD_SETUP  +: CNT_W];
   assign c_stb = tim[FLD_STROBE +: CNT_W];
   assign c_hld = tim[FLD_HOLD   +: CNT_W];
   assign acc_end = (state_r == ST_TURN) && tmr_last;
   // Every phase is a whole number of clock periods
   ams_phase_timer u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (tmr_load),
      .load_val (tmr_val),
      .last     (tmr_last)
   );
   always_comb begin
      state_nxt   = state_r;
      tmr_load    = 1'b0;
      tmr_val     = '0;
      isw_nxt     = isw_r;
      pa_nxt      = pa_r;
      pd_nxt      = pd_r;
      cap_nxt     = cap_r;
      cap_vld_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (go_rd || go_wr) begin
               isw_nxt   = go_wr;
               pa_nxt    = addr_r;
               pd_nxt    = wdat_r;
               state_nxt = ST_SETUP;
               tmr_load  = 1'b1;
               tmr_val   = go_wr ? wtim_r[FLD_SETUP +: CNT_W]
                                 : rtim_r[FLD_SETUP +: CNT_W];
            end
         end
         ST_SETUP: begin
            if (tmr_last) begin
               state_nxt = ST_STROBE;
               tmr_load  = 1'b1;
               tmr_val   = c_stb;
            end
         end
         ST_STROBE: begin
            if (tmr_last) begin
               state_nxt = ST_HOLD;
               tmr_load  = 1'b1;
               tmr_val   = c_hld;
               if (!isw_r) begin
                  // Sampled on the edge where OE goes high
                  cap_nxt     = ext_data_in;
                  cap_vld_nxt = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            if (tmr_last) begin
               state_nxt = ST_TURN;
               tmr_load  = 1'b1;
               tmr_val   = turn_r;
            end
         end
         ST_TURN: begin
            if (tmr_last) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      cs_nxt  = !(state_nxt inside {ST_SETUP, ST_STROBE, ST_HOLD});
      oe_nxt  = !(state_nxt == ST_STROBE && !isw_nxt);
      we_nxt  = !(state_nxt == ST_STROBE && isw_nxt);
      // Bus driven only inside a write, so reads never fight
      doe_nxt = isw_nxt && !cs_nxt;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r   <= ST_IDLE;
         isw_r     <= 1'b0;
         pa_r      <= '0;
         pd_r      <= '0;
         cap_r     <= '0;
         cap_vld_r <= 1'b0;
         cs_r      <= 1'b1;
         oe_r      <= 1'b1;
         we_r      <= 1'b1;
         doe_r     <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         isw_r     <= isw_nxt;
         pa_r      <= pa_nxt;
         pd_r      <= pd_nxt;
         cap_r     <= cap_nxt;
         cap_vld_r <= cap_vld_nxt;
         cs_r      <= cs_nxt;
         oe_r      <= oe_nxt;
         we_r      <= we_nxt;
         doe_r     <= doe_nxt;
      end
   end
   assign ext_chip_select_n   = cs_r;
   assign ext_output_enable_n = oe_r;
   assign ext_write_enable_n  = we_r;
   assign ext_word_address    = pa_r[WADDR_W-1:0];
   assign ext_byte_address    = pa_r[FLD_BADDR +: BADDR_W];
   assign ext_data_out        = pd_r;
   assign ext_data_oe         = doe_r;

   // ==========================================================
   // Checks
   logic [ACC_W-1:0] ph_r, acc_r, acc_want;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_r  <= '0;
         acc_r <= '0;
      end else begin
         ph_r  <= tmr_load ? '0 : ACC_W'(ph_r + 1'b1);
         acc_r <= (state_r == ST_IDLE) ? '0 : ACC_W'(acc_r + 1'b1);
      end
   end
   assign acc_want = ACC_W'(c_set) + ACC_W'(c_stb) + ACC_W'(c_hld)
                     + ACC_W'(turn_r) + ACC_W'(PHASES - 1);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_PHASE_WHOLE: assert property (
      state_r != state_nxt && busy |-> tmr_last)
      else $error("phase left before its count ran out");
   AST_READ_CYCLE: assert property (
      acc_end && !isw_r |-> acc_r == acc_want)
      else $error("read access length wrong");
   AST_WRITE_CYCLE: assert property (
      acc_end && isw_r |-> acc_r == acc_want)
      else $error("write access length wrong");
   AST_TURN_LEN: assert property (
      acc_end |-> ph_r == ACC_W'(turn_r))
      else $error("turnaround length wrong");
   AST_READ_SETUP: assert property (
      $fell(ext_output_enable_n) |-> $past(ph_r) == ACC_W'(c_set)
         && $stable(ext_word_address) && $stable(ext_byte_address))
      else $error("read setup length wrong");
   AST_OE_WIDTH: assert property (
      $rose(ext_output_enable_n) |-> $past(ph_r) == ACC_W'(c_stb))
      else $error("output enable width wrong");
   AST_READ_HOLD: assert property (
      state_r == ST_HOLD && tmr_last && !isw_r
         |-> ph_r == ACC_W'(c_hld) && !ext_chip_select_n ##1
             $stable(ext_word_address))
      else $error("read hold length wrong");
   AST_READ_CAPTURE: assert property (
      $rose(ext_output_enable_n) |-> cap_r == $past(ext_data_in)
         ##1 rdat_r == $past(cap_r))
      else $error("read data not captured at OE rise");
   AST_WRITE_SETUP: assert property (
      $fell(ext_write_enable_n) |-> $past(ph_r) == ACC_W'(c_set))
      else $error("write setup length wrong");
   AST_WE_WIDTH: assert property (
      $rose(ext_write_enable_n) |-> $past(ph_r) == ACC_W'(c_stb))
      else $error("write enable width wrong");
   AST_WRITE_HOLD: assert property (
      state_r == ST_HOLD && tmr_last && isw_r |-> ph_r == ACC_W'(c_hld)
         && ext_data_oe && !ext_chip_select_n ##1 $stable(ext_word_address))
      else $error("write hold broken");
   AST_WDATA_SETUP: assert property (
      $fell(ext_write_enable_n) |-> $past(ext_data_oe)
         && $stable(ext_data_out))
      else $error("write data not driven before WE low");
   AST_WDATA_HOLD: assert property (
      ext_data_oe && $past(ext_data_oe) |-> $stable(ext_data_out)
         && $stable(ext_word_address))
      else $error("write data changed while driven");
   AST_CS_SPAN: assert property (
      !ext_chip_select_n == (state_r inside {ST_SETUP, ST_STROBE,
                                             ST_HOLD}))
      else $error("chip select outside access");
   AST_IDLE_QUIET: assert property (
      state_r inside {ST_IDLE, ST_TURN} |-> ext_chip_select_n
         && ext_output_enable_n && ext_write_enable_n && !ext_data_oe)
      else $error("port active while idle");
   COV_READ: cover property (acc_end && !isw_r);
   COV_WRITE: cover property (acc_end && isw_r);
   COV_LONG: cover property (acc_end && acc_r > ACC_W'(8));
   COV_DONE_RACE: cover property (acc_end && reg_wr
                                  && reg_addr == OFS_STATUS);
endmodule // ams_async_mem_seq
`default_nettype wire

//--- ams_pkg.sv
// Constants for the asynchronous memory access sequencer
package ams_pkg;
   // ==========================================================
   // Widths
   localparam int unsigned CNT_W   = 4;
   localparam int unsigned WADDR_W = 22;
   localparam int unsigned BADDR_W = 2;
   localparam int unsigned DATA_W  = 16;
   localparam int unsigned RADDR_W = 8;
   localparam int unsigned RDATA_W = 32;
   localparam int unsigned ACC_W   = 7;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_RTIM   = 8'h00;
   localparam logic [7:0] OFS_WTIM   = 8'h04;
   localparam logic [7:0] OFS_TURN   = 8'h08;
   localparam logic [7:0] OFS_ADDR   = 8'h0C;
   localparam logic [7:0] OFS_WDATA  = 8'h10;
   localparam logic [7:0] OFS_CMD    = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_RDATA  = 8'h1C;
   // ==========================================================
   // Field positions
   localparam int unsigned FLD_SETUP  = 0;
   localparam int unsigned FLD_STROBE = 4;
   localparam int unsigned FLD_HOLD   = 8;
   localparam int unsigned TIM_W      = 12;
   localparam int unsigned FLD_BADDR  = 22;
   localparam int unsigned CMD_READ   = 0;
   localparam int unsigned CMD_WRITE  = 1;
   localparam int unsigned STS_BUSY   = 0;
   localparam int unsigned STS_DONE   = 1;
   localparam int unsigned STS_WRITE  = 2;
   // ==========================================================
   // Reset values
   localparam logic [TIM_W-1:0] RST_TIM  = 12'h000;
   localparam logic [CNT_W-1:0] RST_TURN = 4'h0;
   // Phases above the data of an access
   localparam int unsigned PHASES = 4;
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_SETUP  = 5'b00010,
      ST_STROBE = 5'b00100,
      ST_HOLD   = 5'b01000,
      ST_TURN   = 5'b10000
   } ams_state_e;
endpackage

//--- ams_phase_timer.sv
// Down counter that measures one phase of an external access
`timescale 1ns/10ps
`default_nettype none
module ams_phase_timer
   import ams_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_val,
   output logic                  last
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // ==========================================================
   // Count
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_val;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // A loaded value N gives N+1 cycles before the next load
   assign last = (cnt_r == '0);
endmodule // ams_phase_timer
`default_nettype wire

//--- ams_sram_model.sv
// Behavioural asynchronous RAM facing the external memory port
`timescale 1ns/10ps
`default_nettype none
module ams_sram_model
   import ams_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               slow,
   input  wire logic               ext_chip_select_n,
   input  wire logic               ext_output_enable_n,
   input  wire logic               ext_write_enable_n,
   input  wire logic [WADDR_W-1:0] ext_word_address,
   input  wire logic [BADDR_W-1:0] ext_byte_address,
   input  wire logic [DATA_W-1:0]  bus_in,
   output logic      [DATA_W-1:0]  bus_out
);
   // ==================
   // Storage
   // Small array: bench locations differ in the low bits
   logic [DATA_W-1:0] mem [0:63];
   logic [DATA_W-1:0] word_q = 16'h0000;
   logic [DATA_W-1:0] last_q = 16'h0000;
   logic [4:0]        oe_cyc = 5'h00;
   logic              drive;
   logic [5:0]        loc;
   assign loc = ext_word_address[5:0];
   always @(posedge core_clk) begin
      if (!ext_chip_select_n && !ext_write_enable_n)
         mem[loc] <= bus_in;
      if (ext_output_enable_n)
         word_q <= mem[loc];
      oe_cyc <= ext_output_enable_n ? 5'h00 : oe_cyc + 5'h01;
      if (drive)
         last_q <= word_q;
   end
   // ==================
   // Read drive
   // Slow part: data valid only from the second strobe cycle
   assign drive = !ext_chip_select_n && !ext_output_enable_n
                  && (!slow || oe_cyc != 5'h00);
   // Lags a nanosecond so data outlive the strobe's rising edge
   assign #1 bus_out = drive ? word_q : ~last_q;
endmodule // ams_sram_model
`default_nettype wire

//--- test_ams_async_mem_seq.sv
// Self-checking testbench for the asynchronous memory sequencer
`timescale 1ns/10ps
`default_nettype none
module test_ams_async_mem_seq
   import ams_pkg::*;
;
   logic               core_clk = 1'b0;
   logic               rst_b = 1'b0;
   logic               slow = 1'b0;
   logic [RADDR_W-1:0] reg_addr = 8'h00;
   logic [RDATA_W-1:0] reg_wdata = 32'h0;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic [RDATA_W-1:0] reg_rdata, rd;
   logic               ext_chip_select_n, ext_output_enable_n;
   logic               ext_write_enable_n, ext_data_oe;
   logic [WADDR_W-1:0] ext_word_address;
   logic [BADDR_W-1:0] ext_byte_address;
   logic [DATA_W-1:0]  ext_data_out, ext_data_in, bus_out;
   logic               mon_on = 1'b0;
   logic               exp_wr = 1'b0;
   logic [23:0]        exp_loc = 24'h0;
   logic [15:0]        exp_dat = 16'h0;
   int bad_count = 0, checks = 0, set_cyc = 0, stb_cyc = 0, hold_cyc = 0;
   int gap_cyc = 0, gap_last = 0, starts = 0;
   int addr_bad = 0, data_bad = 0, idle_bad = 0;
   always #2.5 core_clk = ~core_clk;
   // Bus wire: the block wins while it drives
   assign ext_data_in = ext_data_oe ? ext_data_out : bus_out;
   ams_async_mem_seq u_ams_async_mem_seq (
      .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .ext_chip_select_n, .ext_output_enable_n,
      .ext_write_enable_n, .ext_word_address, .ext_byte_address,
      .ext_data_in, .ext_data_out, .ext_data_oe
   );
   ams_sram_model u_ams_sram_model (
      .core_clk, .slow, .ext_chip_select_n, .ext_output_enable_n,
      .ext_write_enable_n, .ext_word_address, .ext_byte_address,
      .bus_in(ext_data_in), .bus_out
   );
   // ==================
   // Port monitor, sampled mid-cycle
   always @(negedge core_clk) begin
      if (mon_on && ext_chip_select_n === 1'b0) begin
         if (gap_cyc != 0) begin
            gap_last = gap_cyc;
            gap_cyc = 0;
            set_cyc = 0;
            stb_cyc = 0;
            hold_cyc = 0;
            starts++;
         end
         if (ext_output_enable_n === 1'b0 || ext_write_enable_n === 1'b0)
            stb_cyc++;
         else if (stb_cyc == 0)
            set_cyc++;
         else
            hold_cyc++;
         if ({ext_byte_address, ext_word_address} !== exp_loc)
            addr_bad++;
         if (ext_data_oe !== exp_wr || (exp_wr && ext_data_out !== exp_dat)
             || (exp_wr ? ext_output_enable_n : ext_write_enable_n) !== 1'b1)
            data_bad++;
      end else if (mon_on) begin
         gap_cyc++;
         if (ext_output_enable_n !== 1'b1 || ext_write_enable_n !== 1'b1
             || ext_data_oe !== 1'b0)
            idle_bad++;
      end
   end
   // ==================
   // Tasks
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      if (bad_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_reset;
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // Back to back: a second start the cycle after busy drops
   task automatic access(input logic wr, input logic [11:0] tim,
                         input logic [3:0] ta, input logic [23:0] loc,
                         input logic [15:0] d, input logic b2b);
      int n;
      int sum;
      int total;
      sum = tim[3:0] + tim[7:4] + tim[11:8] + ta + 4;
      exp_wr = wr;
      exp_loc = loc;
      exp_dat = d;
      reg_write(wr ? OFS_WTIM : OFS_RTIM, {20'h0, tim});
      reg_write(OFS_TURN, {28'h0, ta});
      reg_write(OFS_ADDR, {8'h0, loc});
      reg_write(OFS_WDATA, {16'h0, d});
      starts = 0;
      addr_bad = 0;
      data_bad = 0;
      @(posedge core_clk);
      reg_addr <= OFS_CMD;
      reg_wdata <= {30'h0, wr | b2b, ~wr};
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      // Repeat the command pulse once the first access ends after sum cycles
      if (b2b) begin
         repeat (sum) @(posedge core_clk);
         reg_wr <= 1'b1;
         @(posedge core_clk);
         reg_wr <= 1'b0;
      end
      for (n = 0; n < 100; n++) begin
         reg_read(OFS_STATUS, rd);
         if (rd[STS_BUSY] === 1'b0)
            break;
      end
      check("status", {29'h0, wr, 2'h2}, rd);
      if (rd[STS_BUSY] !== 1'b0)
         complete_run();
      check("setup", tim[3:0] + 32'h1, set_cyc);
      check("strobe", tim[7:4] + 32'h1, stb_cyc);
      check("hold", tim[11:8] + 32'h1, hold_cyc);
      check("address", 32'h0, addr_bad);
      check("data bus", 32'h0, data_bad);
      check("starts", b2b ? 32'h2 : 32'h1, starts);
      if (b2b) begin
         check("gap", ta + 32'h2, gap_last);
         total = set_cyc + stb_cyc + hold_cyc + gap_last - 1;
         check("cycle", sum, total);
      end
      if (!wr) begin
         reg_read(OFS_RDATA, rd);
         check("read data", {16'h0, d}, rd);
      end
      reg_write(OFS_STATUS, 32'h2);
   endtask
   // ==================
   // Sequence
   initial begin
      do_reset();
      mon_on = 1'b1;
      reg_read(8'h20, rd);
      check("unmapped", 32'h0, rd);
      access(1'b1, 12'h000, 4'h0, 24'h000001, 16'hA5C3, 1'b0);
      access(1'b0, 12'h000, 4'h0, 24'h000001, 16'hA5C3, 1'b0);
      access(1'b1, 12'h123, 4'h2, 24'hC00002, 16'h5A3C, 1'b1);
      slow <= 1'b1;
      access(1'b0, 12'h321, 4'h3, 24'hC00002, 16'h5A3C, 1'b1);
      access(1'b1, 12'hFFF, 4'hF, 24'h400003, 16'hFFFF, 1'b1);
      access(1'b0, 12'hFFF, 4'hF, 24'h400003, 16'hFFFF, 1'b0);
      // Reset in mid-access must drop chip select and data drive at once, with WE high
      mon_on = 1'b0;
      reg_write(OFS_CMD, 32'h2);
      @(posedge core_clk);
      rst_b <= 1'b0;
      #1;
      check("reset pins", 32'h7, {29'h0, ext_chip_select_n,
            ext_write_enable_n, ~ext_data_oe});
      do_reset();
      reg_read(OFS_WTIM, rd);
      check("timing reset", {20'h0, RST_TIM}, rd);
      reg_read(OFS_TURN, rd);
      check("turn reset", {28'h0, RST_TURN}, rd);
      check("idle pins", 32'h0, idle_bad);
      complete_run();
   end
endmodule // test_ams_async_mem_seq
`default_nettype wire
